//--- design/dac_defines.vh
// Operation
// - every falling conversion-clock edge starts a new conversion unless powered down.
// - a result reaches the data outputs five conversion clocks after its start.
// - continuously, a fresh value is readable after each falling conversion edge.
// - a read is decoded from both chip selects and the read strobe in strobe mode, or the store strobe high in rw-select mode.
// - with two channels the marker is low while first-channel data is out.
// - with one input selected the marker stays inactive high.
// - first marker after marker reset comes seven plus channel-count clocks later.
// - output coding is straight binary or twos complement per format bit.
// - binary coding gives 3ff, 200, 000 for full, mid and zero scale.
// - twos complement gives 1ff, 000, 200 for full, mid and zero scale.
// - exactly two ten-bit configuration registers exist.
// - primary register holds test, scan, diff, select, power, spare, reference fields.
// - secondary register holds offset, format, strobe mode, soft reset, reset control.
// - address 00 primary, 01 secondary, address bit1 high is reserved.
// - external reference is used only when programmed external.
// - hardware reset returns both configuration registers to defaults.
// - store strobe is read/write select or active-low write strobe.
// - ten data pins carry results and register values, pin 0 is lsb.
`ifndef DAC_DEFINES_VH
`define DAC_DEFINES_VH
`define DAC_W            10
`define DAC_PRI_RST      10'h020
`define DAC_SEC_RST      10'h000
`define DAC_F_VREF       0
`define DAC_F_PD         2
`define DAC_F_CHSEL_LO   3
`define DAC_F_CHSEL_HI   4
`define DAC_F_DIFF_LO    5
`define DAC_F_DIFF_HI    6
`define DAC_F_SCAN       7
`define DAC_F_TEST_LO    8
`define DAC_F_TEST_HI    9
`define DAC_F_CTLRST     0
`define DAC_F_SOFT_RESET_BIT       1
`define DAC_F_STBMODE    6
`define DAC_F_FORMAT     7
`define DAC_F_OFFSET     8
`define DAC_LATENCY      5
`define DAC_SYNC_BASE    4'h7
`define DAC_SCAN_CHANS   4'h2
`define DAC_MID_CODE     10'h200
`endif

//--- design/dac_host_if.v
`include "dac_defines.vh"
`timescale 1ns/100ps
`default_nettype none
module dac_host_if
(
  input  wire        clk_sys_i,         // system clock 100 MHz
  input  wire        rst_n_i,           // async reset, active low
  input  wire        clk_en_i,          // freezes all state while low
  input  wire        hw_reset_i,        // hardware reset pin, active high
  input  wire        conversion_clock_in_i,        // conversion_clock_in pin
  input  wire        chip_select_low_n_i, // chip_select_low, active low
  input  wire        chip_select_high_i,  // chip_select_high, active high
  input  wire        read_strobe_n_i,   // read strobe, active low
  input  wire        store_strobe_i,    // r/w select or write strobe low
  input  wire        reg_addr_bit0_i,   // register address bit 0
  input  wire        reg_addr_bit1_i,   // register address bit 1
  input  wire [9:0]  data_in_i,         // data pins, input side
  input  wire [9:0]  sample_a_i,        // analog front end word, input a
  input  wire [9:0]  sample_b_i,        // analog front end word, input b
  output reg  [9:0]  data_out_o,        // data pins, output side
  output reg         data_oe_n_o,       // data pin enable, low drives
  output reg         channel_a_marker_o, // low while first-channel word out
  output reg         ext_ref_sel_o,     // external reference in use
  output reg         power_down_o,      // converter core powered down
  output reg  [1:0]  selftest_sel_o,    // test voltage select
  output reg         conv_start_o       // one-cycle pulse per conversion
);

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers: two flops each, nothing reads stage one

  localparam NSYNC = 18;
  wire [NSYNC-1:0] raw_w;
  reg  [NSYNC-1:0] s1_q;
  reg  [NSYNC-1:0] s2_q;
  assign raw_w = {data_in_i, hw_reset_i, conversion_clock_in_i, chip_select_low_n_i,
                  chip_select_high_i, read_strobe_n_i, store_strobe_i,
                  reg_addr_bit0_i, reg_addr_bit1_i};

  always @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s1_q <= {NSYNC{1'b1}};
      s2_q <= {NSYNC{1'b1}};
    end
    else if (clk_en_i)
    begin
      s1_q <= raw_w;
      s2_q <= s1_q;
    end
  end

  wire [9:0] din_w   = s2_q[17:8];
  wire       hwrst_w = s2_q[7];
  wire       cclk_w  = s2_q[6];
  wire       csl_n_w = s2_q[5];
  wire       csh_w   = s2_q[4];
  wire       rd_n_w  = s2_q[3];
  wire       st_w    = s2_q[2];
  wire       ra0_w   = s2_q[1];
  wire       ra1_w   = s2_q[0];

  ////////////////////////////////////////////////////////////////////////////
  // access decode

  reg        cclk_q;
  reg        wr_act_q;
  reg  [9:0] cfg_pri_q;
  reg  [9:0] cfg_sec_q;

  wire sel_w     = !csl_n_w && csh_w;
  wire wmode_w   = cfg_sec_q[`DAC_F_STBMODE];
  // rw-select mode: store high reads, low writes; strobe mode: separate strobes
  wire rd_act_w  = sel_w && (wmode_w ? !rd_n_w : st_w);
  wire wr_lvl_w  = sel_w && (wmode_w ? !st_w : !st_w && rd_n_w);
  wire wr_end_w  = wr_act_q && !wr_lvl_w;
  wire cfall_w   = cclk_q && !cclk_w;
  wire soft_rst_w = cfg_sec_q[`DAC_F_SOFT_RESET_BIT] || cfg_sec_q[`DAC_F_CTLRST];

  function [1:0] dac_chans;
    input [9:0] pri;
    begin
      dac_chans = pri[`DAC_F_SCAN] ? 2'd2 : 2'd1;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers, latched at end of write so data is settled

  reg        wr_a0_q;
  reg        wr_a1_q;
  reg  [9:0] wr_d_q;

  always @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cclk_q    <= 1'b1;
      wr_act_q  <= 1'b0;
      wr_a0_q   <= 1'b0;
      wr_a1_q   <= 1'b1;
      wr_d_q    <= 10'h000;
      cfg_pri_q <= `DAC_PRI_RST;
      cfg_sec_q <= `DAC_SEC_RST;
    end
    else if (clk_en_i)
    begin
      cclk_q   <= cclk_w;
      wr_act_q <= wr_lvl_w;
      if (wr_lvl_w)
      begin
        wr_a0_q <= ra0_w;
        wr_a1_q <= ra1_w;
        wr_d_q  <= din_w;
      end
      if (hwrst_w)
      begin
        cfg_pri_q <= `DAC_PRI_RST;
        cfg_sec_q <= `DAC_SEC_RST;
      end
      else if (wr_end_w && !wr_a1_q)
      begin
        // address bit1 high is reserved and dropped
        if (!wr_a0_q)
          cfg_pri_q <= wr_d_q;
        else
          cfg_sec_q <= wr_d_q;
      end
      else if (soft_rst_w)
      begin
        // self-clearing reset bits; keep strobe mode so the bus stays usable
        cfg_pri_q <= `DAC_PRI_RST;
        cfg_sec_q <= `DAC_SEC_RST | (cfg_sec_q & (10'h001 << `DAC_F_STBMODE));
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // conversion pipeline: per falling edge sample, deliver after latency

  reg [9:0] pipe_q  [0:`DAC_LATENCY-1];
  reg       pch_q   [0:`DAC_LATENCY-1];
  reg       ch_q;
  reg [3:0] sync_cnt_q;
  reg       out_ch_q;
  reg [9:0] out_q;

  wire       two_w   = dac_chans(cfg_pri_q) == 2'd2;
  wire [9:0] raw_s_w = (two_w && ch_q) ? sample_b_i :
                       (!two_w && cfg_pri_q[`DAC_F_CHSEL_LO]) ? sample_b_i : sample_a_i;
  // converter core supplies offset binary; msb flip gives twos complement
  wire [9:0] fmt_w   = cfg_sec_q[`DAC_F_FORMAT] ? (raw_s_w ^ `DAC_MID_CODE)
                                                 : raw_s_w;
  // the marker is forced high in single mode, so only the two-channel count is ever used
  wire [3:0] sync_first_w = `DAC_SYNC_BASE + `DAC_SCAN_CHANS;

  genvar g;
  generate
    for (g = 1; g < `DAC_LATENCY; g = g + 1)
    begin : g_pipe
      always @(posedge clk_sys_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
        begin
          pipe_q[g] <= 10'h000;
          pch_q[g]  <= 1'b0;
        end
        else if (clk_en_i && cfall_w)
        begin
          pipe_q[g] <= pipe_q[g-1];
          pch_q[g]  <= pch_q[g-1];
        end
      end
    end
  endgenerate

  always @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pipe_q[0]          <= 10'h000;
      pch_q[0]           <= 1'b0;
      ch_q               <= 1'b1;
      sync_cnt_q         <= 4'h0;
      out_ch_q           <= 1'b0;
      out_q              <= 10'h000;
      conv_start_o       <= 1'b0;
      channel_a_marker_o <= 1'b1;
      data_out_o         <= 10'h000;
      data_oe_n_o        <= 1'b1;
      ext_ref_sel_o      <= 1'b0;
      power_down_o       <= 1'b0;
      selftest_sel_o     <= 2'b00;
    end
    else if (clk_en_i)
    begin
      conv_start_o <= cfall_w && !cfg_pri_q[`DAC_F_PD];
      if (cfall_w)
      begin
        pipe_q[0] <= fmt_w;
        pch_q[0]  <= ch_q;
        ch_q      <= two_w ? !ch_q : 1'b0;
        out_q     <= pipe_q[`DAC_LATENCY-1];
        out_ch_q  <= pch_q[`DAC_LATENCY-1];
        if (sync_cnt_q != 4'h0)
          sync_cnt_q <= sync_cnt_q - 4'h1;
      end
      if (hwrst_w || soft_rst_w || !two_w)
      begin
        // marker reset: restart channel order and the pipeline fill count
        // second input converts first so the first marker lands on a first-channel word
        ch_q       <= 1'b1;
        sync_cnt_q <= sync_first_w;
      end
      if (!two_w)
        channel_a_marker_o <= 1'b1;
      else
        channel_a_marker_o <= !(sync_cnt_q == 4'h0 && !out_ch_q);
      data_oe_n_o    <= !rd_act_w;
      data_out_o     <= out_q;
      ext_ref_sel_o  <= cfg_pri_q[`DAC_F_VREF];
      power_down_o   <= cfg_pri_q[`DAC_F_PD];
      selftest_sel_o <= {cfg_pri_q[`DAC_F_TEST_HI], cfg_pri_q[`DAC_F_TEST_LO]};
    end
  end

endmodule
`default_nettype wire

//--- sim/dac_host_if_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module dac_host_if_assertions
(
  input wire logic       clk_sys_i,           // clock
  input wire logic       rst_n_i,             // reset
  input wire logic       hw_reset_i,          // reset pin
  input wire logic       conversion_clock_in_i,          // conv clock
  input wire logic       chip_select_low_n_i, // select
  input wire logic       chip_select_high_i,  // select
  input wire logic       read_strobe_n_i,     // read
  input wire logic       store_strobe_i,      // store
  input wire logic       data_oe_n_o,         // pin enable
  input wire logic [9:0] data_out_o,          // result
  input wire logic       channel_a_marker_o,  // marker
  input wire logic       ext_ref_sel_o,       // reference
  input wire logic       power_down_o,        // power down
  input wire logic [1:0] selftest_sel_o,      // test
  input wire logic       conv_start_o         // start
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);
  wire sel = !chip_select_low_n_i && chip_select_high_i;
  ////////////////////
  // a read in either strobe mode: rw-select high and read strobe low
  sequence rd_held;
    (sel && store_strobe_i && !read_strobe_n_i) [*5];
  endsequence
  sequence b_word;
    channel_a_marker_o [*6];
  endsequence
  chk_read_drive: assert property (rd_held |-> !data_oe_n_o)
    else $error("read not answered");
  chk_idle_float: assert property ((!sel) [*5] |-> data_oe_n_o)
    else $error("pins driven unselected");
  chk_conv_start: assert property ($fell(conversion_clock_in_i) && !power_down_o |-> ##[2:4] conv_start_o)
    else $error("no conversion start");
  chk_start_pulse: assert property (conv_start_o |=> !conv_start_o [*3])
    else $error("start pulse too long");
  chk_data_when: assert property (!$stable(data_out_o) |-> $past(conv_start_o) || $past(conv_start_o, 2))
    else $error("result moved off conversion");
  chk_marker_low: assert property ($fell(channel_a_marker_o) |-> !channel_a_marker_o [*6])
    else $error("first word too short");
  chk_marker_alt: assert property ($fell(channel_a_marker_o) |-> ##[6:10] b_word)
    else $error("second word missing");
  chk_hw_defaults: assert property (hw_reset_i [*3] |-> ##[0:3]
    (!power_down_o && !ext_ref_sel_o && selftest_sel_o == 2'b00 && channel_a_marker_o))
    else $error("hardware reset defaults");
endmodule
bind dac_host_if dac_host_if_assertions chk_u (.clk_sys_i, .rst_n_i, .hw_reset_i, .conversion_clock_in_i,
  .chip_select_low_n_i, .chip_select_high_i, .read_strobe_n_i, .store_strobe_i, .data_oe_n_o,
  .data_out_o, .channel_a_marker_o, .ext_ref_sel_o, .power_down_o, .selftest_sel_o, .conv_start_o);
`default_nettype wire

//--- sim/dac_host_mdl.sv
`timescale 1ns/100ps
`default_nettype none
module dac_host_mdl
(
  input  wire logic       clk_sys_i,  // clock
  input  wire logic [9:0] data_i,     // device pins
  input  wire logic       oe_n_i,     // device enable
  output var  logic       conversion_clock_in_o, // conv clock
  output var  logic       cs_lo_n_o,  // select low
  output var  logic       cs_hi_o,    // select high
  output var  logic       rd_n_o,     // read strobe
  output var  logic       store_o,    // store strobe
  output var  logic [1:0] addr_o,     // address
  output var  logic [9:0] wdata_o     // data out
);
  logic [1:0] ph_q;
  initial
  begin
    {ph_q, conversion_clock_in_o, cs_lo_n_o, cs_hi_o, rd_n_o, store_o} = 7'b0011011;
    addr_o = 2'b00;
    wdata_o = 10'h155;
  end
  // eight system clocks a period, halves equal
  always @(negedge clk_sys_i)
  begin
    ph_q <= ph_q + 2'd1;
    if (ph_q == 2'd3)
      conversion_clock_in_o <= !conversion_clock_in_o;
  end
  task automatic wr(input logic [1:0] a, input logic [9:0] v);
    @(negedge clk_sys_i);
    {cs_lo_n_o, cs_hi_o, store_o, addr_o, wdata_o} = {3'b010, a, v};
    repeat (5) @(negedge clk_sys_i);
    // released data is not left showing the written word
    {cs_lo_n_o, cs_hi_o, store_o, wdata_o} = {3'b101, ~v};
    repeat (2) @(negedge clk_sys_i);
  endtask
  task automatic rd(input logic rn, output logic [10:0] seen);
    @(negedge clk_sys_i);
    {cs_lo_n_o, cs_hi_o, rd_n_o} = {2'b01, rn};
    repeat (5) @(negedge clk_sys_i);
    seen = {oe_n_i, data_i};
    {cs_lo_n_o, cs_hi_o, rd_n_o} = 3'b101;
    repeat (4) @(negedge clk_sys_i);
  endtask
endmodule
`default_nettype wire

//--- sim/dac_host_if_test.sv
`include "dac_defines.vh"
`timescale 1ns/100ps
`default_nettype none
module dac_host_if_test;
  logic        clk_sys_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        hw_reset_i = 1'b0;
  logic [9:0]  sample_a = 10'h000;
  logic [9:0]  sample_b = 10'h000;
  logic [9:0]  prev = 10'h000;
  logic [9:0]  v;
  logic [10:0] seen;
  logic        ok;
  logic [9:0]  corner [3] = '{10'h3ff, 10'h200, 10'h000};
  int          n_mismatch = 0;
  int          n_compared = 0;
  wire         conversion_clock_in, cs_lo_n, cs_hi, rd_n, store, oe_n, marker, ext_ref, pd;
  wire [1:0]   addr, tsel;
  wire [9:0]   wdata, dout;
  wire [9:0]   pins = oe_n ? wdata : dout;
  always #5 clk_sys_i = !clk_sys_i;
  dac_host_mdl model_u (.clk_sys_i(clk_sys_i), .data_i(dout), .oe_n_i(oe_n), .conversion_clock_in_o(conversion_clock_in),
    .cs_lo_n_o(cs_lo_n), .cs_hi_o(cs_hi), .rd_n_o(rd_n), .store_o(store), .addr_o(addr), .wdata_o(wdata));
  dac_host_if dut_u (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .clk_en_i(1'b1), .hw_reset_i(hw_reset_i),
    .conversion_clock_in_i(conversion_clock_in), .chip_select_low_n_i(cs_lo_n), .chip_select_high_i(cs_hi), .read_strobe_n_i(rd_n),
    .store_strobe_i(store), .reg_addr_bit0_i(addr[0]), .reg_addr_bit1_i(addr[1]), .data_in_i(pins),
    .sample_a_i(sample_a), .sample_b_i(sample_b), .data_out_o(dout), .data_oe_n_o(oe_n),
    .channel_a_marker_o(marker), .ext_ref_sel_o(ext_ref), .power_down_o(pd), .selftest_sel_o(tsel),
    .conv_start_o());
  ////////////////////
  task automatic check(input string what, input logic [10:0] got, input logic [10:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [9:0] fmt(input logic [9:0] s, input logic tc);
    return tc ? {~s[9], s[8:0]} : s;
  endfunction
  task automatic edges(input int n);
    repeat (n) @(negedge conversion_clock_in);
    repeat (6) @(negedge clk_sys_i);
  endtask
  task automatic lat(input logic [9:0] s, input logic tc);
    @(negedge conversion_clock_in);
    {sample_a, sample_b} = {s, s};
    edges(`DAC_LATENCY - 1);
    check("stale word", {oe_n, dout}, {1'b1, fmt(prev, tc)});
    edges(1);
    check("result word", {oe_n, dout}, {1'b1, fmt(s, tc)});
    prev = s;
  endtask
  task automatic final_report;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  ////////////////////
  initial
  begin
    void'($urandom(32'h25814a3e));
    repeat (3) @(negedge clk_sys_i);
    rst_n_i = 1'b1;
    check("defaults", {5'h00, ext_ref, pd, tsel, marker, oe_n}, 11'h003);
    v = {2'($urandom), 8'h21};
    model_u.wr(2'b00, v);
    model_u.wr(2'b10, 10'h3fe);
    repeat (8) @(negedge clk_sys_i);
    check("primary", {7'h00, ext_ref, pd, tsel}, {7'h02, v[9:8]});
    @(negedge clk_sys_i) hw_reset_i = 1'b1;
    repeat (4) @(negedge clk_sys_i);
    hw_reset_i = 1'b0;
    repeat (6) @(negedge clk_sys_i);
    check("hw defaults", {5'h00, ext_ref, pd, tsel, marker, oe_n}, 11'h003);
    $display("test config done");
    model_u.rd(1'b1, seen);
    check("rw read", {seen[10], 10'h000}, 11'h000);
    model_u.wr(2'b01, 10'h040);
    model_u.rd(1'b1, seen);
    check("strobe idle", {seen[10], 10'h000}, 11'h400);
    model_u.rd(1'b0, seen);
    check("strobe read", {seen[10], 10'h000}, 11'h000);
    $display("test strobes done");
    for (int f = 0; f < 2; f++)
    begin
      model_u.wr(2'b01, {2'b00, f[0], 7'h00});
      edges(6);
      foreach (corner[i])
        lat(corner[i], f[0]);
      repeat (3)
        lat(10'($urandom), f[0]);
    end
    ok = 1'b1;
    repeat (40) @(negedge clk_sys_i) ok &= marker;
    check("single marker", {10'h000, ok}, 11'h001);
    $display("test coding done");
    sample_a = 10'($urandom);
    sample_b = ~sample_a;
    @(negedge conversion_clock_in);
    repeat (3) @(negedge clk_sys_i);
    model_u.wr(2'b00, 10'h088);
    edges(`DAC_SYNC_BASE + 1);
    check("marker early", {10'h000, marker}, 11'h001);
    edges(1);
    check("a word", {marker, dout}, {1'b0, fmt(sample_a, 1'b1)});
    edges(1);
    check("b word", {marker, dout}, {1'b1, fmt(sample_b, 1'b1)});
    edges(1);
    check("a again", {marker, dout}, {1'b0, fmt(sample_a, 1'b1)});
    $display("test two channel done");
    final_report;
  end
  // the run needs under 2k cycles; ten times that means a hang
  initial
  begin
    #200us;
    n_mismatch++;
    final_report;
  end
endmodule
`default_nettype wire
